// ===== dtcr_top.sv
// four-channel cycle-steal transfer engine: request latching, fixed priority,
// bus phase sequencing with per-side cycle counts, and a small register port.
// assumes one clock, a bus arbiter answering bus_req_o, and a cpu access strobe.
//
// Notes on behaviour
// R1: a unit is a source read phase followed by a destination write phase.
// R2: in expansion mode the byte pin also forces an 8-bit side.
// R3: 16-bit unit at odd address on 16-bit bus needs two reads, two writes.
// R4: 16-bit unit between two 8-bit sides: two byte reads, two byte writes.
// R5: 8-bit source to 16-bit destination: two byte reads, one word write.
// R6: 16-bit source to 8-bit destination: one word read, two byte writes.
// R7: special function area or waited memory adds one cycle per access.
// R8: 8-bit unit always one read and one write; 8-bit bus only in expansion.
// R9: unit cycles equal reads times read coefficient plus writes times write one.
// R10: triggers come from peripherals, software writes, or external pin edges.
// R11: a request is served only while pending and mode is single or repeat.
// R12: a pending request with mode disabled is dropped without transfer.
// R13: reset puts every mode to disabled; software enables after setup.
// R14: channel 0 wins over 1, 2, 3; one unit per grant.
// R15: bus goes back after each unit; next start waits for one cpu access.
// R16: pending bit clears at transfer start or while disabled.
// R17: a request on an already pending channel merges into that one.
//////////////////////////////////////////////////////////////////////////////
package dtcr_pkg;
  localparam int         NCH       = 4;
  localparam logic [1:0] MODE_OFF  = 2'h0;
  localparam logic [1:0] MODE_SGL  = 2'h1;
  localparam logic [1:0] MODE_RPT  = 2'h3;
  localparam logic [3:0] ADDR_STAT = 4'h4;
  localparam int         F_MODE    = 0;
  localparam int         F_U16     = 2;
  localparam int         F_SW16    = 3;
  localparam int         F_DW16    = 4;
  localparam int         F_SODD    = 5;
  localparam int         F_DODD    = 6;
  localparam int         F_SJ      = 7;
  localparam int         F_DK      = 9;
  localparam int         F_SEL     = 11;
  localparam int         F_SSFA    = 13;
  localparam int         F_DSFA    = 14;
  localparam int         F_SWREQ   = 15;
  localparam logic [1:0] SEL_PER   = 2'h0;
  localparam logic [1:0] SEL_SOFT  = 2'h1;
  localparam logic [1:0] SEL_EXTF  = 2'h2;
  localparam logic [1:0] SEL_EXTB  = 2'h3;
  localparam logic [15:0] CFG_RST  = 16'h0000;
  localparam int         BUF_DEPTH = 2;
  typedef enum logic [1:0] {ST_IDLE, ST_RD, ST_WR, ST_GAP} dtcr_state_t;
endpackage
//////////////////////////////////////////////////////////////////////////////
module dtcr_top #(
  parameter int DW = 16
) (
  input  wire logic          clk_i,
  input  wire logic          sys_rst_i,
  input  wire logic          ce_i,
  input  wire logic [3:0]    reg_addr_i,
  input  wire logic [15:0]   reg_wdata_i,
  input  wire logic          reg_wr_i,
  input  wire logic          reg_rd_i,
  output logic      [15:0]   reg_rdata_o,
  input  wire logic [3:0]    periph_req_i,
  input  wire logic [3:0]    ext_int_i,
  input  wire logic          byte_pin_i,
  input  wire logic          mem_exp_i,
  input  wire logic          bus_gnt_i,
  input  wire logic          cpu_acc_done_i,
  input  wire logic          bus_rdy_i,
  input  wire logic [DW-1:0] bus_rdata_i,
  output logic               bus_req_o,
  output logic               bus_rd_o,
  output logic               bus_wr_o,
  output logic               bus_byte_o,
  output logic               bus_hi_o,
  output logic      [1:0]    bus_ch_o,
  output logic      [DW-1:0] bus_wdata_o,
  output logic               unit_done_o
);
  // two accesses when a 16-bit unit is split into bytes
  function automatic logic two_acc(input logic u16, input logic odd, input logic b8);
    return u16 & (odd | b8); // R3 R4 R5 R6 R8
  endfunction
  // access length in cycles: base field plus one, plus one more for the special area
  function automatic logic [2:0] coef(input logic [1:0] base, input logic sfa);
    return {1'b0, base} + 3'h1 + {2'h0, sfa}; // R7 R9
  endfunction
  // cycles one side takes for a unit
  function automatic logic [3:0] side_cyc(input logic two, input logic [2:0] eff);
    return two ? {eff, 1'b0} : {1'b0, eff};
  endfunction
  // lowest set index wins
  function automatic logic [1:0] pick(input logic [3:0] v);
    logic [1:0] r;
    r = 2'h0;
    for (int i = dtcr_pkg::NCH - 1; i >= 0; i--) begin
      if (v[i]) r = 2'(i);
    end
    return r;
  endfunction

  logic [15:0]   cfg_q [4];
  logic [15:0]   cfg_d [4];
  logic [3:0]    pend_q, pend_d, trig, elig, clr;
  logic [3:0]    ext_s1_q, ext_s2_q, ext_s3_q;
  logic          byte_s1_q, byte_s2_q;
  logic [15:0]   rdata_q, rdata_d;
  dtcr_pkg::dtcr_state_t st_q, st_d;
  logic [1:0]    ch_q, ch_d, win;
  logic          idx_q, idx_d, two_rd_q, two_rd_d, two_wr_q, two_wr_d;
  logic [2:0]    cnt_q, cnt_d, jeff_q, jeff_d, keff_q, keff_d;
  logic [7:0]    asm_q, asm_d, cyc_q, cyc_d;
  logic          start, push, pop, done;
  logic [DW-1:0] push_data;
  logic [DW-1:0] buf_q [dtcr_pkg::BUF_DEPTH];
  logic          wp_q, rp_q;
  logic [1:0]    fill_q;
  logic          buf_in_rdy, buf_out_vld;

  //////////////////////////////////////////////////////////////////////////////
  // pin synchronisers; only the second and third stages feed logic
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ext_s1_q  <= 4'hf; // pins idle high: a zero here would fake an edge
      ext_s2_q  <= 4'hf;
      ext_s3_q  <= 4'hf;
      byte_s1_q <= 1'b0;
      byte_s2_q <= 1'b0;
    end else if (ce_i) begin
      ext_s1_q  <= ext_int_i;
      ext_s2_q  <= ext_s1_q;
      ext_s3_q  <= ext_s2_q;
      byte_s1_q <= byte_pin_i;
      byte_s2_q <= byte_s1_q;
    end
  end

  // trigger selection, pending latch and register port
  always_comb begin
    rdata_d = 16'h0000;
    for (int c = 0; c < dtcr_pkg::NCH; c++) begin
      cfg_d[c] = cfg_q[c];
      case (cfg_q[c][dtcr_pkg::F_SEL +: 2]) // R10
        dtcr_pkg::SEL_PER:  trig[c] = periph_req_i[c];
        dtcr_pkg::SEL_EXTF: trig[c] = ext_s3_q[c] & ~ext_s2_q[c];
        dtcr_pkg::SEL_EXTB: trig[c] = ext_s3_q[c] ^ ext_s2_q[c];
        default:            trig[c] = 1'b0;
      endcase
      if (reg_wr_i && reg_addr_i == 4'(c)) begin
        cfg_d[c] = {1'b0, reg_wdata_i[14:0]};
        // software request bit is a strobe, never stored
        if (reg_wdata_i[dtcr_pkg::F_SWREQ] && reg_wdata_i[dtcr_pkg::F_SEL +: 2] == dtcr_pkg::SEL_SOFT) begin
          trig[c] = 1'b1; // R10
        end
      end
      elig[c] = pend_q[c] && (cfg_q[c][1:0] == dtcr_pkg::MODE_SGL || cfg_q[c][1:0] == dtcr_pkg::MODE_RPT); // R11
      clr[c]  = start && win == 2'(c); // R16
      // a new trigger beats the start clear, extra triggers merge
      pend_d[c] = (pend_q[c] & ~clr[c]) | trig[c]; // R17
      // disabled wins over any trigger: requests are dropped
      if (cfg_q[c][1:0] == dtcr_pkg::MODE_OFF) pend_d[c] = 1'b0; // R12 R16
    end
    if (reg_rd_i) begin
      if (reg_addr_i < dtcr_pkg::ADDR_STAT) rdata_d = cfg_q[reg_addr_i[1:0]];
      else if (reg_addr_i == dtcr_pkg::ADDR_STAT) rdata_d = {cyc_q, 1'b0, ch_q, st_q != dtcr_pkg::ST_IDLE, pend_q};
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      for (int c = 0; c < dtcr_pkg::NCH; c++) cfg_q[c] <= dtcr_pkg::CFG_RST; // R13
      pend_q  <= 4'h0;
      rdata_q <= 16'h0000;
    end else if (ce_i) begin
      for (int c = 0; c < dtcr_pkg::NCH; c++) cfg_q[c] <= cfg_d[c];
      pend_q  <= pend_d;
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata_o = rdata_q;

  property p_off_drop;
    @(posedge clk_i) disable iff (sys_rst_i)
      ce_i && cfg_q[0][1:0] == dtcr_pkg::MODE_OFF |=> !pend_q[0];
  endproperty
  a_off_drop: assert property (p_off_drop) else $error("pending kept while disabled"); // R12

  property p_merge;
    @(posedge clk_i) disable iff (sys_rst_i)
      ce_i && trig[1] && cfg_q[1][1:0] != dtcr_pkg::MODE_OFF |=> pend_q[1];
  endproperty
  a_merge: assert property (p_merge) else $error("trigger lost"); // R17

  //////////////////////////////////////////////////////////////////////////////
  // unit sequencer: grant, read phase, write phase, then give way to the cpu
  assign win = pick(elig); // R14
  always_comb begin
    logic [15:0] cf;
    logic        sb8, db8;
    cf = cfg_q[win];
    // the 8-bit side only exists off-chip, in expansion mode
    sb8 = mem_exp_i & (~cf[dtcr_pkg::F_SW16] | byte_s2_q); // R2 R8
    db8 = mem_exp_i & (~cf[dtcr_pkg::F_DW16] | byte_s2_q); // R2 R8
    st_d = st_q;  ch_d = ch_q;  idx_d = idx_q;  cnt_d = cnt_q;
    two_rd_d = two_rd_q;  two_wr_d = two_wr_q;
    jeff_d = jeff_q;  keff_d = keff_q;  asm_d = asm_q;  cyc_d = cyc_q;
    start = 1'b0;  push = 1'b0;  pop = 1'b0;  done = 1'b0;
    push_data = two_rd_q ? {bus_rdata_i[7:0], asm_q} : bus_rdata_i; // R5
    case (st_q)
      dtcr_pkg::ST_IDLE: begin
        if (|elig && bus_gnt_i) begin // R11 R14
          start    = 1'b1;
          st_d     = dtcr_pkg::ST_RD; // R1
          ch_d     = win;
          idx_d    = 1'b0;
          two_rd_d = two_acc(cf[dtcr_pkg::F_U16], cf[dtcr_pkg::F_SODD], sb8);
          two_wr_d = two_acc(cf[dtcr_pkg::F_U16], cf[dtcr_pkg::F_DODD], db8);
          jeff_d   = coef(cf[dtcr_pkg::F_SJ +: 2], cf[dtcr_pkg::F_SSFA]);
          keff_d   = coef(cf[dtcr_pkg::F_DK +: 2], cf[dtcr_pkg::F_DSFA]);
          cnt_d    = jeff_d;
          cyc_d    = 8'(side_cyc(two_rd_d, jeff_d)) + 8'(side_cyc(two_wr_d, keff_d)); // R9
        end
      end
      dtcr_pkg::ST_RD: begin
        if (cnt_q != 3'h1) cnt_d = cnt_q - 3'h1; // R7
        else if (bus_rdy_i) begin
          if (two_rd_q && !idx_q) begin
            asm_d = bus_rdata_i[7:0]; // R4 R5
            idx_d = 1'b1;
            cnt_d = jeff_q;
          end else if (buf_in_rdy) begin // a full buffer holds the read open
            push  = 1'b1;
            st_d  = dtcr_pkg::ST_WR; // R1
            idx_d = 1'b0;
            cnt_d = keff_q;
          end
        end
      end
      dtcr_pkg::ST_WR: begin
        if (cnt_q != 3'h1) cnt_d = cnt_q - 3'h1; // R7
        else if (bus_rdy_i && buf_out_vld) begin
          if (two_wr_q && !idx_q) begin
            idx_d = 1'b1; // R4 R6
            cnt_d = keff_q;
          end else begin
            pop  = 1'b1;
            done = 1'b1;
            st_d = dtcr_pkg::ST_GAP; // R15
          end
        end
      end
      dtcr_pkg::ST_GAP: begin
        if (cpu_acc_done_i) st_d = dtcr_pkg::ST_IDLE; // R15
      end
      default: st_d = dtcr_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      st_q <= dtcr_pkg::ST_IDLE;  ch_q <= 2'h0;  idx_q <= 1'b0;  cnt_q <= 3'h1;
      two_rd_q <= 1'b0;  two_wr_q <= 1'b0;  jeff_q <= 3'h1;  keff_q <= 3'h1;
      asm_q <= 8'h00;  cyc_q <= 8'h00;
    end else if (ce_i) begin
      st_q <= st_d;  ch_q <= ch_d;  idx_q <= idx_d;  cnt_q <= cnt_d;
      two_rd_q <= two_rd_d;  two_wr_q <= two_wr_d;  jeff_q <= jeff_d;  keff_q <= keff_d;
      asm_q <= asm_d;  cyc_q <= cyc_d;
    end
  end

  // phase outputs decode from the flops; unit_done_o also follows bus_rdy_i and ce_i
  assign bus_req_o   = (st_q == dtcr_pkg::ST_IDLE && |elig) || st_q == dtcr_pkg::ST_RD || st_q == dtcr_pkg::ST_WR;
  assign bus_rd_o    = st_q == dtcr_pkg::ST_RD;
  assign bus_wr_o    = st_q == dtcr_pkg::ST_WR && buf_out_vld;
  assign bus_byte_o  = bus_rd_o ? two_rd_q : (bus_wr_o & two_wr_q);
  assign bus_hi_o    = bus_byte_o & idx_q;
  assign bus_ch_o    = ch_q;
  assign unit_done_o = done & ce_i;

  property p_prio;
    @(posedge clk_i) disable iff (sys_rst_i)
      ce_i && start && elig[0] |-> win == 2'h0;
  endproperty
  a_prio: assert property (p_prio) else $error("channel 0 skipped"); // R14

  property p_start_clr;
    @(posedge clk_i) disable iff (sys_rst_i)
      ce_i && start && !trig[win] |=> !pend_q[ch_q];
  endproperty
  a_start_clr: assert property (p_start_clr) else $error("pending not cleared at start"); // R16

  property p_gap;
    @(posedge clk_i) disable iff (sys_rst_i)
      ce_i && done |=> st_q == dtcr_pkg::ST_GAP && !bus_req_o;
  endproperty
  a_gap: assert property (p_gap) else $error("bus kept after unit"); // R15

  property p_byte_unit;
    @(posedge clk_i) disable iff (sys_rst_i)
      ce_i && start && !cfg_q[win][dtcr_pkg::F_U16] |=> !two_rd_q && !two_wr_q;
  endproperty
  a_byte_unit: assert property (p_byte_unit) else $error("8-bit unit split"); // R8

  property p_narrow;
    @(posedge clk_i) disable iff (sys_rst_i)
      ce_i && start && cfg_q[win][dtcr_pkg::F_U16] && mem_exp_i && !cfg_q[win][dtcr_pkg::F_SW16] |=> two_rd_q;
  endproperty
  a_narrow: assert property (p_narrow) else $error("8-bit source read once"); // R4

  property p_cycles;
    @(posedge clk_i) disable iff (sys_rst_i)
      ce_i && start |=> cyc_q == ({5'h00, jeff_q} << two_rd_q) + ({5'h00, keff_q} << two_wr_q);
  endproperty
  a_cycles: assert property (p_cycles) else $error("unit cycle total wrong"); // R9

  property p_rd_first;
    @(posedge clk_i) disable iff (sys_rst_i)
      ce_i && start |=> bus_rd_o && !bus_wr_o;
  endproperty
  a_rd_first: assert property (p_rd_first) else $error("unit did not open with a read"); // R1

  //////////////////////////////////////////////////////////////////////////////
  // two-entry buffer between read and write phase
  assign buf_in_rdy  = fill_q != 2'(dtcr_pkg::BUF_DEPTH);
  assign buf_out_vld = fill_q != 2'h0;
  assign bus_wdata_o = buf_q[rp_q];
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      for (int i = 0; i < dtcr_pkg::BUF_DEPTH; i++) buf_q[i] <= '0;
      wp_q <= 1'b0;  rp_q <= 1'b0;  fill_q <= 2'h0;
    end else if (ce_i) begin
      if (push) buf_q[wp_q] <= push_data;
      wp_q   <= wp_q ^ push;
      rp_q   <= rp_q ^ pop;
      fill_q <= fill_q + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule // dtcr_top

// ===== dtcr_bus_model.sv
// bus-side partner of the transfer engine: arbiter grant, access ready,
// read data and cpu access pulses.
// assumes the same clock and reset as dtcr_top, outputs change after the edge.
module dtcr_bus_model (
  input  wire logic        clk_i,
  input  wire logic        sys_rst_i,
  input  wire logic        slow_i,
  input  wire logic        bus_req_i,
  output logic             bus_gnt_o,
  output logic             bus_rdy_o,
  output logic             cpu_acc_done_o,
  output logic      [15:0] bus_rdata_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] rnd_q;
  logic [15:0] rnd_d;
  //////////////////////////////////////////////////////////////////////////////
  // pattern moves every cycle, so a word read at the wrong moment never matches
  always_comb begin
    rnd_d = {rnd_q[14:0], rnd_q[15] ^ rnd_q[13] ^ rnd_q[12] ^ rnd_q[10]};
  end
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rnd_q <= 16'h5a3c;
    end else begin
      rnd_q <= rnd_d;
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  // slow mode withholds grant and ready on random cycles
  assign bus_gnt_o      = !slow_i | rnd_q[0] | rnd_q[1];
  assign bus_rdy_o      = !slow_i | rnd_q[2] | rnd_q[5];
  // the cpu only completes an access while the engine has let the bus go
  assign cpu_acc_done_o = !bus_req_i & (slow_i ? (rnd_q[4:3] == 2'h0) : rnd_q[3]);
  assign bus_rdata_o    = rnd_q;
endmodule // dtcr_bus_model

// ===== test_dma_transfer_cycle_and_request.sv
// self-checking bench for dtcr_top: random unit shapes, all trigger sources,
// disabled-mode drops, priority order and request merging.
// assumes dtcr_pkg compiled first and dtcr_bus_model as the bus partner.
module test_dma_transfer_cycle_and_request;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_i, sys_rst_i, reg_wr, reg_rd, mem_exp, byte_pin, slow, gnt, rdy, cpu_done, ce;
  logic        bus_req, bus_rd, bus_wr, unit_done, seen_cpu, rd_prev, bus_byte, bus_hi, last_bw, last_hi;
  logic [3:0]  reg_addr, periph, ext, chn;
  logic [15:0] reg_wdata, reg_rdata, rdata, v, cfg, wdata, last_wd, exp_wd;
  logic [15:0] rq[$];
  logic [1:0]  bus_ch, sel, mode;
  logic [31:0] lfsr_q;
  int          failures, total_checks, n_done, rd_n, wr_n, last_rd, last_wr, d0, i, k, er, ew, rn, wn;
  int          ch_q[$];
  dtcr_top uut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .ce_i(ce), .reg_addr_i(reg_addr),
    .reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_rdata_o(reg_rdata),
    .periph_req_i(periph), .ext_int_i(ext), .byte_pin_i(byte_pin), .mem_exp_i(mem_exp),
    .bus_gnt_i(gnt), .cpu_acc_done_i(cpu_done), .bus_rdy_i(rdy), .bus_rdata_i(rdata),
    .bus_req_o(bus_req), .bus_rd_o(bus_rd), .bus_wr_o(bus_wr), .bus_byte_o(bus_byte), .bus_hi_o(bus_hi),
    .bus_ch_o(bus_ch), .bus_wdata_o(wdata), .unit_done_o(unit_done));
  dtcr_bus_model partner (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .slow_i(slow), .bus_req_i(bus_req),
    .bus_gnt_o(gnt), .bus_rdy_o(rdy), .cpu_acc_done_o(cpu_done), .bus_rdata_o(rdata));
  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic complete_run();
    if (failures == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_i);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk_i);
    reg_wr    <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk_i);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk_i);
    reg_rd   <= 1'b0;
    #1 d = reg_rdata;
  endtask
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // reference: access counts per side times that side's coefficient
  function automatic void unit_model(input logic [15:0] c, input logic ex, input logic bp,
                                     output int rj, output int wk, output int rn, output int wn);
    int r, w;
    r  = (c[dtcr_pkg::F_U16] && (c[dtcr_pkg::F_SODD] || (ex && (!c[dtcr_pkg::F_SW16] || bp)))) ? 2 : 1;
    w  = (c[dtcr_pkg::F_U16] && (c[dtcr_pkg::F_DODD] || (ex && (!c[dtcr_pkg::F_DW16] || bp)))) ? 2 : 1;
    rj = r * (int'(c[dtcr_pkg::F_SJ+:2]) + 1 + int'(c[dtcr_pkg::F_SSFA]));
    wk = w * (int'(c[dtcr_pkg::F_DK+:2]) + 1 + int'(c[dtcr_pkg::F_DSFA]));
    rn = r;
    wn = w;
  endfunction
  //////////////////////////////////////////////////////////////////////////////
  // bus monitor: phase order, cycles per side, cpu access between units
  always @(posedge clk_i) begin
    if (cpu_done === 1'b1) seen_cpu = 1'b1;
    if (bus_rd === 1'b1 && rd_prev !== 1'b1) begin
      chk(seen_cpu, 1'b1);
      rd_n = 0;
      wr_n = 0;
      rq.delete();
    end
    if (bus_rd === 1'b1) begin
      rd_n++;
      rq.push_back(rdata);
      chk(wr_n, 0);
    end
    if (bus_wr === 1'b1) wr_n++;
    if (unit_done === 1'b1) begin
      n_done++;
      last_rd  = rd_n;
      last_wr  = wr_n;
      last_wd  = wdata;
      last_bw  = bus_byte;
      last_hi  = bus_hi;
      seen_cpu = 1'b0;
      ch_q.push_back(bus_ch);
    end
    rd_prev = bus_rd;
  end
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end
  // watchdog sized well above the longest expected run
  initial begin
    repeat (40000) @(posedge clk_i);
    failures++;
    complete_run();
  end
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    sys_rst_i = 1'b1; reg_wr = 1'b0; reg_rd = 1'b0; reg_addr = 4'h0; reg_wdata = 16'h0000;
    periph = 4'h0; ext = 4'hf; mem_exp = 1'b0; byte_pin = 1'b0; slow = 1'b0;
    lfsr_q = 32'h879d; seen_cpu = 1'b1; rd_prev = 1'b0; ce = 1'b1;
    repeat (20) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    // all channel words and status clear, unmapped address reads zero
    for (i = 0; i < 6; i++) begin
      rd(i[3:0], v);
      chk(v, 16'h0000);
    end
    // requests on disabled channels are dropped
    d0 = n_done;
    // mode 10 is neither off nor enabled: request is kept but never served
    wr(4'h0, 16'h0802);
    wr(4'h0, 16'h8802);
    repeat (10) @(posedge clk_i);
    rd(4'h4, v);
    chk(v[3:0], 4'h1);
    wr(4'h0, 16'h8800);
    @(posedge clk_i);
    periph <= 4'h2;
    @(posedge clk_i);
    periph <= 4'h0;
    repeat (10) @(posedge clk_i);
    rd(4'h4, v);
    chk(v[3:0], 4'h0);
    chk(n_done, d0);
    // random unit shapes through every trigger source
    for (i = 0; i < 24; i++) begin
      lfsr_q = lfsr(lfsr(lfsr_q));
      sel  = i[1:0];
      mode = lfsr_q[16] ? dtcr_pkg::MODE_RPT : dtcr_pkg::MODE_SGL;
      cfg  = (lfsr_q[15:0] & 16'h67fc) | {3'h0, sel, 11'h000} | {14'h0000, mode};
      mem_exp  <= lfsr_q[20];
      byte_pin <= lfsr_q[21];
      slow     <= (i >= 16);
      chn = {2'h0, lfsr_q[25:24]};
      wr(chn, cfg & 16'hfffc);
      wr(chn, cfg);
      d0 = n_done;
      if (sel == dtcr_pkg::SEL_PER) begin
        periph <= 4'h1 << chn;
        @(posedge clk_i);
        periph <= 4'h0;
      end else if (sel == dtcr_pkg::SEL_SOFT) begin
        wr(chn, cfg | 16'h8000);
      end else begin
        if (sel == dtcr_pkg::SEL_EXTF) begin
          ext[chn] <= 1'b1;
          repeat (6) @(posedge clk_i);
        end
        ext[chn] <= ~ext[chn];
      end
      for (k = 0; k < 400 && n_done == d0; k++) @(posedge clk_i);
      repeat (30) @(posedge clk_i);
      unit_model(cfg, mem_exp, byte_pin, er, ew, rn, wn);
      rd(4'h4, v);
      chk(n_done, d0 + 1);
      chk(v[15:8], er + ew);
      chk(v[3:0], 4'h0);
      if (!slow) begin
        chk(last_rd, er);
        chk(last_wr, ew);
        // split reads: first byte low, second high, each taken at its access end
        exp_wd = (rn == 2) ? {rq[er-1][7:0], rq[er/2-1][7:0]} : rq[er-1];
        chk(last_wd, exp_wd);
        chk({last_bw, last_hi}, (wn == 2) ? 2'h3 : 2'h0);
      end
    end
    // all four at once, channel 3 triggered twice while pending
    slow <= 1'b0;
    for (i = 0; i < 4; i++) wr(i[3:0], {14'h0000, dtcr_pkg::MODE_SGL});
    ch_q.delete();
    d0 = n_done;
    @(posedge clk_i);
    periph <= 4'hf;
    @(posedge clk_i);
    periph <= 4'h8;
    @(posedge clk_i);
    periph <= 4'h0;
    // freeze mid-service: nothing may be lost or repeated across the stall
    @(posedge clk_i);
    ce <= 1'b0;
    repeat (3) @(posedge clk_i);
    ce <= 1'b1;
    for (k = 0; k < 600 && n_done < d0 + 4; k++) @(posedge clk_i);
    repeat (50) @(posedge clk_i);
    chk(n_done, d0 + 4);
    for (i = 0; i < 4 && i < ch_q.size(); i++) chk(ch_q[i], i);
    complete_run();
  end
endmodule // test_dma_transfer_cycle_and_request
